/* logic/timer8_pkg.sv */
// Shared constants and types of the 8-bit timer status and data block
package timer8_pkg;

   localparam int unsigned DATA_W = 32;
   localparam int unsigned ADDR_W = 12;

   // Register indices; byte address is four times the index
   localparam logic [6:0] IDX_CTL_B = 7'h3C;
   localparam logic [6:0] IDX_CTL_A = 7'h3D;
   localparam logic [6:0] IDX_FLAGS = 7'h3E;
   localparam logic [6:0] IDX_CAP_ONE = 7'h3F;
   localparam logic [6:0] IDX_CMP_ONE = 7'h40;
   localparam logic [6:0] IDX_CNT = 7'h41;
   localparam logic [6:0] IDX_CNT_ALT = 7'h42;
   localparam logic [6:0] IDX_CAP_TWO = 7'h43;
   localparam logic [6:0] IDX_CMP_TWO = 7'h44;
   localparam logic [6:0] IDX_IRQ_STS = 7'h45;
   localparam logic [6:0] IDX_IRQ_MSK = 7'h46;

   // timer_control_a fields
   localparam int unsigned CA_CAP_IE = 7;
   localparam int unsigned CA_CMP_IE = 6;
   localparam int unsigned CA_OVF_IE = 5;
   localparam int unsigned CA_FORCE_TWO = 4;
   localparam int unsigned CA_FORCE_ONE = 3;
   localparam int unsigned CA_LEVEL_TWO = 2;
   localparam int unsigned CA_EDGE_ONE = 1;
   localparam int unsigned CA_LEVEL_ONE = 0;

   // timer_control_b fields
   localparam int unsigned CB_PIN_EN_ONE = 7;
   localparam int unsigned CB_PIN_EN_TWO = 6;
   localparam int unsigned CB_ONE_PULSE = 5;
   localparam int unsigned CB_PWM = 4;
   localparam int unsigned CB_CLK_HI = 3;
   localparam int unsigned CB_CLK_LO = 2;
   localparam int unsigned CB_EDGE_TWO = 1;
   localparam int unsigned CB_RSVD = 0;

   // Flag vector index; also the flag's bit minus 3 in the flags register
   localparam int unsigned FL_CAP_ONE = 4;
   localparam int unsigned FL_CMP_ONE = 3;
   localparam int unsigned FL_OVF = 2;
   localparam int unsigned FL_CAP_TWO = 1;
   localparam int unsigned FL_CMP_TWO = 0;
   localparam int unsigned FLAG_HI = 7;
   localparam int unsigned FLAG_LO = 3;
   localparam int unsigned DISABLE_BIT = 2;

   localparam logic [7:0] CTL_RESET = 8'h00;
   localparam logic [7:0] CMP_RESET = 8'h00;
   localparam logic [7:0] CNT_RESET = 8'hFC;
   localparam logic [7:0] CNT_MAX = 8'hFF;
   localparam logic [4:0] FLAGS_RESET = 5'h00;

   // Prescaler terminal counts (divide minus one)
   localparam logic [12:0] DIV2_LAST = 13'h0001;
   localparam logic [12:0] DIV4_LAST = 13'h0003;
   localparam logic [12:0] DIV8_LAST = 13'h0007;

   typedef enum logic [1:0] {
      CLK_DIV4 = 2'b00,
      CLK_DIV2 = 2'b01,
      CLK_DIV8 = 2'b10,
      CLK_SLOW = 2'b11
   } clk_sel_t;

endpackage : timer8_pkg

/* logic/timer8_cap_if.sv */
// Capture edge selects and capture events between core and capture unit
`timescale 1ns/1ps
interface timer8_cap_if;
   logic [1:0] edge_sel;
   logic [1:0] cap_evt;
   modport core (output edge_sel, input cap_evt);
   modport cap (input edge_sel, output cap_evt);
endinterface : timer8_cap_if

/* logic/timer8_capture.sv */
// Capture pin synchronisers and edge detectors
`timescale 1ns/1ps
module timer8_capture (
   input wire logic clk, // System clock
   input wire logic nrst, // Async reset, active low
   input wire logic pin_one, // Capture pin one
   input wire logic pin_two, // Capture pin two
   timer8_cap_if.cap bus // Edge selects in, events out
);
   import timer8_pkg::*;

   logic [1:0] pins;
   logic [1:0] primed_r;

   assign pins = {pin_two, pin_one};

   // Gates edges off for the first two cycles, while the synchroniser still holds its reset value
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         primed_r <= 2'h0;
      end else begin
         primed_r <= {primed_r[0], 1'b1};
      end
   end

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_cap
         logic meta_r;
         logic sync_r;
         logic hist_r;
         logic evt_r;
         logic rise;
         logic fall;
         assign rise = sync_r & ~hist_r;
         assign fall = ~sync_r & hist_r;
         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               meta_r <= 1'b0;
               sync_r <= 1'b0;
               hist_r <= 1'b0;
               evt_r <= 1'b0;
            end else begin
               meta_r <= pins[g];
               sync_r <= meta_r;
               hist_r <= sync_r;
               evt_r <= primed_r[1] & (bus.edge_sel[g] ? rise : fall);
            end
         end
         assign bus.cap_evt[g] = evt_r;
      end
   endgenerate

endmodule : timer8_capture

/* logic/timer8_status_data_regs.sv */
// 8-bit free-running timer: flags, data registers, counter, APB slave
//
// Overview of operation
// - Edge select two: 0 falling, 1 rising
// - Flags register resets zero; only bit 2 writable
// - Capture flag one: capture or PWM period
// - Compare flag one on compare one match
// - Overflow flag on wrap, cleared via counter access
// - Alternate counter reads counter, never clears overflow
// - Capture flag two on capture two event
// - Compare flag two on compare two match
// - Disable bit freezes timer, disables output pins
// - Registers stay accessible while timer disabled
// - Capture loads counter; no reset value
// - Compare registers writable, reset zero, compared continuously
// - Counters reset to FCh; write resets counter
// - Interrupt from flags gated by their enables
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
module timer8_status_data_regs #(
   parameter int unsigned SLOW_DIV = 8000 // Slow clock divide, in clk cycles
) (
   input wire logic clk, // 200 MHz system clock
   input wire logic nrst, // Async reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction, high writes
   input wire logic [timer8_pkg::ADDR_W-1:0] paddr, // APB byte address
   input wire logic [timer8_pkg::DATA_W-1:0] pwdata, // APB write data
   output logic [timer8_pkg::DATA_W-1:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error, unmapped address
   input wire logic capture_input_one, // Capture pin one
   input wire logic capture_input_two, // Capture pin two
   output logic compare_output_one, // Compare pin one level
   output logic compare_output_one_en, // Compare pin one enable
   output logic compare_output_two, // Compare pin two level
   output logic compare_output_two_en, // Compare pin two enable
   output logic irq // Timer interrupt, level
);
   import timer8_pkg::*;

   function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [6:0] idx);
      reg_hit = (a == {3'h0, idx, 2'h0});
   endfunction : reg_hit

   localparam logic [12:0] SLOW_LAST = 13'(SLOW_DIV - 1);

   // Register state
   logic [7:0] ctl_a_r;
   logic [7:0] ctl_b_r;
   logic timer_disable_bit_r;
   logic [4:0] flag_r;
   logic [4:0] arm_r;
   logic [7:0] cap_one_r;
   logic [7:0] cap_two_r;
   logic [7:0] cmp_one_r;
   logic [7:0] cmp_two_r;
   logic [7:0] cnt_r;
   logic [12:0] presc_r;
   logic [4:0] sts_r;
   logic [4:0] msk_r;
   logic ocmp_one_r;
   logic ocmp_two_r;
   logic [DATA_W-1:0] prdata_r;

   // Next values
   logic [7:0] cnt_nxt;
   logic [12:0] presc_nxt;
   logic [4:0] flag_nxt;
   logic [4:0] arm_nxt;
   logic [4:0] sts_nxt;
   logic ocmp_one_nxt;
   logic ocmp_two_nxt;

   // Bus decode
   logic setup;
   logic acc;
   logic wr;
   logic rd;
   logic sel_ctl_b;
   logic sel_ctl_a;
   logic sel_flags;
   logic sel_cap_one;
   logic sel_cmp_one;
   logic sel_cnt;
   logic sel_cnt_alt;
   logic sel_cap_two;
   logic sel_cmp_two;
   logic sel_sts;
   logic sel_msk;
   logic hit_any;
   logic [7:0] rd_mux;
   logic [7:0] flags_val;

   // Timer datapath
   logic pwm_mode;
   logic opm_mode;
   logic normal_mode;
   clk_sel_t clk_sel;
   logic [12:0] div_last;
   logic tick;
   logic [7:0] cnt_inc;
   logic cnt_wr;
   logic cap_one_ev;
   logic cap_two_ev;
   logic opm_trig;
   logic pwm_wrap;
   logic match_one;
   logic match_two;
   logic ovf_ev;
   logic force_one;
   logic force_two;
   logic [4:0] set_v;
   logic [4:0] clr_v;
   logic [4:0] sts_w1c;
   logic flags_rd;
   logic irq_flags;
   logic irq_own;

   timer8_cap_if cap_bus();

   timer8_capture u_capture (
      .clk(clk),
      .nrst(nrst),
      .pin_one(capture_input_one),
      .pin_two(capture_input_two),
      .bus(cap_bus.cap)
   );

   assign cap_bus.edge_sel = {ctl_b_r[CB_EDGE_TWO], ctl_a_r[CA_EDGE_ONE]};
   assign cap_one_ev = cap_bus.cap_evt[0];
   assign cap_two_ev = cap_bus.cap_evt[1];

   // APB decode; zero wait states
   assign setup = psel & ~penable;
   assign acc = psel & penable;
   assign wr = acc & pwrite;
   assign rd = acc & ~pwrite;
   assign sel_ctl_b = reg_hit(paddr, IDX_CTL_B);
   assign sel_ctl_a = reg_hit(paddr, IDX_CTL_A);
   assign sel_flags = reg_hit(paddr, IDX_FLAGS);
   assign sel_cap_one = reg_hit(paddr, IDX_CAP_ONE);
   assign sel_cmp_one = reg_hit(paddr, IDX_CMP_ONE);
   assign sel_cnt = reg_hit(paddr, IDX_CNT);
   assign sel_cnt_alt = reg_hit(paddr, IDX_CNT_ALT);
   assign sel_cap_two = reg_hit(paddr, IDX_CAP_TWO);
   assign sel_cmp_two = reg_hit(paddr, IDX_CMP_TWO);
   assign sel_sts = reg_hit(paddr, IDX_IRQ_STS);
   assign sel_msk = reg_hit(paddr, IDX_IRQ_MSK);
   assign hit_any = sel_ctl_b | sel_ctl_a | sel_flags | sel_cap_one | sel_cmp_one | sel_cnt
                  | sel_cnt_alt | sel_cap_two | sel_cmp_two | sel_sts | sel_msk;
   assign pready = 1'b1;
   assign pslverr = acc & ~hit_any;
   assign prdata = prdata_r;

   // Reserved bits 1:0 always read zero
   assign flags_val = {flag_r, timer_disable_bit_r, 2'h0};

   assign rd_mux = sel_ctl_b ? ctl_b_r :
                   sel_ctl_a ? ctl_a_r :
                   sel_flags ? flags_val :
                   sel_cap_one ? cap_one_r :
                   sel_cmp_one ? cmp_one_r :
                   (sel_cnt | sel_cnt_alt) ? cnt_r :
                   sel_cap_two ? cap_two_r :
                   sel_cmp_two ? cmp_two_r :
                   sel_sts ? {3'h0, sts_r} :
                   sel_msk ? {3'h0, msk_r} :
                   8'h00;

   // Modes; PWM takes priority over one-pulse
   assign pwm_mode = ctl_b_r[CB_PWM];
   assign opm_mode = ctl_b_r[CB_ONE_PULSE] & ~pwm_mode;
   assign normal_mode = ~pwm_mode & ~opm_mode;
   assign clk_sel = clk_sel_t'(ctl_b_r[CB_CLK_HI:CB_CLK_LO]);

   assign div_last = (clk_sel == CLK_DIV2) ? DIV2_LAST :
                     (clk_sel == CLK_DIV4) ? DIV4_LAST :
                     (clk_sel == CLK_DIV8) ? DIV8_LAST :
                     SLOW_LAST;

   // >= so a smaller divide chosen mid-count still wraps at once
   assign tick = ~timer_disable_bit_r & (presc_r >= div_last);
   assign cnt_inc = cnt_r + 8'h01;
   assign cnt_wr = wr & (sel_cnt | sel_cnt_alt);
   assign opm_trig = opm_mode & cap_one_ev & ~timer_disable_bit_r;
   assign pwm_wrap = pwm_mode & tick & (cnt_r == cmp_two_r);

   assign cnt_nxt = cnt_wr ? CNT_RESET :
                    opm_trig ? CNT_RESET :
                    pwm_wrap ? CNT_RESET :
                    tick ? cnt_inc :
                    cnt_r;

   assign presc_nxt = (cnt_wr | opm_trig | tick) ? 13'h0000 :
                      timer_disable_bit_r ? presc_r :
                      presc_r + 13'h0001;

   // Compare runs on the value the counter takes at this tick
   assign match_one = tick & ~pwm_wrap & (cnt_inc == cmp_one_r);
   assign match_two = tick & ~pwm_wrap & (cnt_inc == cmp_two_r);
   assign ovf_ev = tick & ~pwm_wrap & (cnt_r == CNT_MAX);

   // Compare flags and pin capture on flag one only in normal mode; PWM period end also sets capture flag one
   assign set_v[FL_CAP_ONE] = (normal_mode & cap_one_ev) | pwm_wrap;
   assign set_v[FL_CMP_ONE] = normal_mode & match_one;
   assign set_v[FL_OVF] = ovf_ev;
   assign set_v[FL_CAP_TWO] = cap_two_ev;
   assign set_v[FL_CMP_TWO] = normal_mode & match_two;

   // Clear needs an earlier flags read that saw the flag set
   assign clr_v[FL_CAP_ONE] = arm_r[FL_CAP_ONE] & acc & sel_cap_one;
   assign clr_v[FL_CMP_ONE] = arm_r[FL_CMP_ONE] & acc & sel_cmp_one;
   assign clr_v[FL_OVF] = arm_r[FL_OVF] & acc & sel_cnt;
   assign clr_v[FL_CAP_TWO] = arm_r[FL_CAP_TWO] & acc & sel_cap_two;
   assign clr_v[FL_CMP_TWO] = arm_r[FL_CMP_TWO] & acc & sel_cmp_two;

   assign flags_rd = rd & sel_flags;
   // Set beats clear in the same cycle
   assign flag_nxt = (flag_r & ~clr_v) | set_v;
   // Arm only what software actually saw in the read data
   assign arm_nxt = flags_rd ? (prdata_r[FLAG_HI:FLAG_LO] & flag_r) : (arm_r & ~clr_v & flag_r);

   assign sts_w1c = (wr & sel_sts) ? pwdata[4:0] : 5'h00;
   assign sts_nxt = (sts_r & ~sts_w1c) | set_v;

   // Output compare pins; forcing only in plain compare mode
   assign force_one = normal_mode & ~timer_disable_bit_r & ctl_a_r[CA_FORCE_ONE];
   assign force_two = normal_mode & ~timer_disable_bit_r & ctl_a_r[CA_FORCE_TWO];

   assign ocmp_one_nxt = (~normal_mode & (pwm_wrap | opm_trig)) ? ctl_a_r[CA_LEVEL_TWO] :
                         (match_one | force_one) ? ctl_a_r[CA_LEVEL_ONE] :
                         ocmp_one_r;
   assign ocmp_two_nxt = (normal_mode & (match_two | force_two)) ? ctl_a_r[CA_LEVEL_TWO] :
                         ocmp_two_r;

   assign compare_output_one = ocmp_one_r;
   assign compare_output_two = ocmp_two_r;
   assign compare_output_one_en = ctl_b_r[CB_PIN_EN_ONE] & ~timer_disable_bit_r;
   assign compare_output_two_en = ctl_b_r[CB_PIN_EN_TWO] & ~timer_disable_bit_r;

   // Interrupt: enabled flags, plus own sticky status under mask
   assign irq_flags = (ctl_a_r[CA_CAP_IE] & (flag_r[FL_CAP_ONE] | flag_r[FL_CAP_TWO]))
                    | (ctl_a_r[CA_CMP_IE] & (flag_r[FL_CMP_ONE] | flag_r[FL_CMP_TWO]))
                    | (ctl_a_r[CA_OVF_IE] & flag_r[FL_OVF]);
   assign irq_own = |(sts_r & msk_r);
   assign irq = irq_flags | irq_own;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ctl_a_r <= CTL_RESET;
      end else if (wr & sel_ctl_a) begin
         ctl_a_r <= pwdata[7:0];
      end
   end

   // Reserved bit is not stored
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ctl_b_r <= CTL_RESET;
      end else if (wr & sel_ctl_b) begin
         ctl_b_r <= {pwdata[7:1], 1'b0};
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         timer_disable_bit_r <= 1'b0;
      end else if (wr & sel_flags) begin
         timer_disable_bit_r <= pwdata[DISABLE_BIT];
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         flag_r <= FLAGS_RESET;
         arm_r <= FLAGS_RESET;
      end else begin
         flag_r <= flag_nxt;
         arm_r <= arm_nxt;
      end
   end

   // Capture registers carry no reset on purpose
   always_ff @(posedge clk) begin
      if (cap_one_ev) begin
         cap_one_r <= cnt_r;
      end
      if (cap_two_ev) begin
         cap_two_r <= cnt_r;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cmp_one_r <= CMP_RESET;
         cmp_two_r <= CMP_RESET;
      end else begin
         if (wr & sel_cmp_one) begin
            cmp_one_r <= pwdata[7:0];
         end
         if (wr & sel_cmp_two) begin
            cmp_two_r <= pwdata[7:0];
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_r <= CNT_RESET;
         presc_r <= 13'h0000;
      end else begin
         cnt_r <= cnt_nxt;
         presc_r <= presc_nxt;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sts_r <= FLAGS_RESET;
         msk_r <= FLAGS_RESET;
      end else begin
         sts_r <= sts_nxt;
         if (wr & sel_msk) begin
            msk_r <= pwdata[4:0];
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ocmp_one_r <= 1'b0;
         ocmp_two_r <= 1'b0;
      end else begin
         ocmp_one_r <= ocmp_one_nxt;
         ocmp_two_r <= ocmp_two_nxt;
      end
   end

   // Read data taken in setup so it is stable through access
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         prdata_r <= '0;
      end else if (setup & ~pwrite) begin
         prdata_r <= {24'h000000, rd_mux};
      end
   end

endmodule : timer8_status_data_regs

/* test/timer8_props.sv */
// Checker for bus answers, register readback and pin enables of the timer
`timescale 1ns/1ps
module timer8_props #(
   parameter int unsigned SLOW_DIV = 8000 // Slow divide
) (
   input wire logic clk, // Clock
   input wire logic nrst, // Reset
   input wire logic psel, // Select
   input wire logic penable, // Enable
   input wire logic pwrite, // Write
   input wire logic [timer8_pkg::ADDR_W-1:0] paddr, // Address
   input wire logic [timer8_pkg::DATA_W-1:0] pwdata, // Write data
   input wire logic [timer8_pkg::DATA_W-1:0] prdata, // Read data
   input wire logic pready, // Ready
   input wire logic pslverr, // Error
   input wire logic capture_input_one, // Pin one
   input wire logic capture_input_two, // Pin two
   input wire logic compare_output_one, // Level one
   input wire logic compare_output_one_en, // Enable one
   input wire logic compare_output_two, // Level two
   input wire logic compare_output_two_en, // Enable two
   input wire logic irq // Interrupt
);
   import timer8_pkg::*;
   localparam logic [11:0] A_LO = {3'h0, IDX_CTL_B, 2'b00};
   localparam logic [11:0] A_HI = {3'h0, IDX_IRQ_MSK, 2'b00};
   localparam logic [11:0] A_CA = {3'h0, IDX_CTL_A, 2'b00};
   localparam logic [11:0] A_FL = {3'h0, IDX_FLAGS, 2'b00};
   localparam logic [11:0] A_C1 = {3'h0, IDX_CMP_ONE, 2'b00};
   localparam logic [11:0] A_C2 = {3'h0, IDX_CMP_TWO, 2'b00};
   logic acc;
   logic rd_acc;
   logic dis_r;
   logic edge_two_r;
   logic [7:0] ctl_a_r;
   logic [7:0] cmp_one_r;
   logic [7:0] cmp_two_r;
   assign acc = psel && penable;
   assign rd_acc = acc && !pwrite;
   // Shadow of software writes, so reads can be judged
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         dis_r <= 1'b0;
         edge_two_r <= 1'b0;
         ctl_a_r <= CTL_RESET;
         cmp_one_r <= CMP_RESET;
         cmp_two_r <= CMP_RESET;
      end else if (acc && pwrite) begin
         if (paddr == A_FL) dis_r <= pwdata[DISABLE_BIT];
         if (paddr == A_LO) edge_two_r <= pwdata[CB_EDGE_TWO];
         if (paddr == A_CA) ctl_a_r <= pwdata[7:0];
         if (paddr == A_C1) cmp_one_r <= pwdata[7:0];
         if (paddr == A_C2) cmp_two_r <= pwdata[7:0];
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   a_ready_access: assert property (acc |-> pready)
      else $error("no ready in access phase");
   a_err_unmapped: assert property (acc && (paddr < A_LO || paddr > A_HI) |-> pslverr)
      else $error("unmapped access without error");
   a_err_idle: assert property (!acc |-> !pslverr)
      else $error("error outside access phase");
   a_rdata_upper: assert property (rd_acc |-> prdata[31:8] == 24'h000000)
      else $error("read data upper bits set");
   a_rdata_holds: assert property (rd_acc |=> $stable(prdata))
      else $error("read data moved after access");
   a_flags_low: assert property (rd_acc && paddr == A_FL |-> prdata[2:0] == {dis_r, 2'b00})
      else $error("flags low bits wrong");
   a_pins_off: assert property (dis_r |-> !compare_output_one_en && !compare_output_two_en)
      else $error("pin enabled while disabled");
   a_edge_two_back: assert property (rd_acc && paddr == A_LO |-> prdata[1:0] == {edge_two_r, 1'b0})
      else $error("edge select readback wrong");
   a_ctl_a_back: assert property (rd_acc && paddr == A_CA |-> prdata[7:0] == ctl_a_r)
      else $error("control a readback wrong");
   a_cmp_one_back: assert property (rd_acc && paddr == A_C1 |-> prdata[7:0] == cmp_one_r)
      else $error("compare one readback wrong");
   a_cmp_two_back: assert property (rd_acc && paddr == A_C2 |-> prdata[7:0] == cmp_two_r)
      else $error("compare two readback wrong");
   c_flags_read: cover property (rd_acc && paddr == A_FL);
   c_irq_rise: cover property ($rose(irq));
   c_err: cover property (pslverr);
endmodule : timer8_props
bind timer8_status_data_regs timer8_props #(.SLOW_DIV(SLOW_DIV)) u_props (.clk(clk), .nrst(nrst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .capture_input_one(capture_input_one),
   .capture_input_two(capture_input_two), .compare_output_one(compare_output_one),
   .compare_output_one_en(compare_output_one_en), .compare_output_two(compare_output_two),
   .compare_output_two_en(compare_output_two_en), .irq(irq));

/* test/timer8_pins.sv */
// Model of the capture sources and compare pin loads
`timescale 1ns/1ps
module timer8_pins (
   input wire logic clk, // Clock
   output logic cap_one, // Capture pin one
   output logic cap_two, // Capture pin two
   input wire logic cmp_one, // Level one
   input wire logic cmp_one_en, // Enable one
   input wire logic cmp_two, // Level two
   input wire logic cmp_two_en, // Enable two
   output wire logic line_one, // Pin one wire
   output wire logic line_two // Pin two wire
);
   // Pull-ups hold the pins once the timer lets go
   assign line_one = cmp_one_en ? cmp_one : 1'b1;
   assign line_two = cmp_two_en ? cmp_two : 1'b1;
   initial begin
      cap_one = 1'b0;
      cap_two = 1'b0;
   end
   // Long settle covers synchroniser plus capture load
   task automatic drive(input int idx, input logic lv);
      if (idx == 1) cap_one <= lv;
      else cap_two <= lv;
      repeat (12) @(posedge clk);
   endtask : drive
endmodule : timer8_pins

/* test/timer8_status_data_regs_tb.sv */
// Register-level bench of the timer block
`timescale 1ns/1ps
module timer8_status_data_regs_tb;
   import timer8_pkg::*;
   localparam logic [11:0] A_CB = {3'h0, IDX_CTL_B, 2'b00};
   localparam logic [11:0] A_CA = {3'h0, IDX_CTL_A, 2'b00};
   localparam logic [11:0] A_FL = {3'h0, IDX_FLAGS, 2'b00};
   localparam logic [11:0] A_P1 = {3'h0, IDX_CAP_ONE, 2'b00};
   localparam logic [11:0] A_C1 = {3'h0, IDX_CMP_ONE, 2'b00};
   localparam logic [11:0] A_CT = {3'h0, IDX_CNT, 2'b00};
   localparam logic [11:0] A_AL = {3'h0, IDX_CNT_ALT, 2'b00};
   localparam logic [11:0] A_P2 = {3'h0, IDX_CAP_TWO, 2'b00};
   localparam logic [11:0] A_C2 = {3'h0, IDX_CMP_TWO, 2'b00};
   localparam logic [11:0] A_ST = {3'h0, IDX_IRQ_STS, 2'b00};
   localparam logic [11:0] A_MK = {3'h0, IDX_IRQ_MSK, 2'b00};
   logic clk, nrst, psel, penable, pwrite, pready, pslverr, irq, er, lv;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q, q2;
   logic cin1, cin2, cmp1, cmp1_en, cmp2, cmp2_en, line_one, line_two;
   int bad_count = 0;
   int n_tests = 0;
   timer8_status_data_regs #(.SLOW_DIV(8)) DUT (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .capture_input_one(cin1), .capture_input_two(cin2), .compare_output_one(cmp1),
      .compare_output_one_en(cmp1_en), .compare_output_two(cmp2), .compare_output_two_en(cmp2_en), .irq(irq));
   timer8_pins pins (.clk(clk), .cap_one(cin1), .cap_two(cin2), .cmp_one(cmp1), .cmp_one_en(cmp1_en),
      .cmp_two(cmp2), .cmp_two_en(cmp2_en), .line_one(line_one), .line_two(line_two));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [31:0] r,
                       output logic e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : xfer
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      xfer(1'b1, a, d, r, e);
   endtask : wr
   task automatic rd(input logic [11:0] a, output logic [31:0] r);
      logic e;
      xfer(1'b0, a, 8'h00, r, e);
   endtask : rd
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic print_verdict;
      if (bad_count == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : print_verdict
   initial begin
      #100000;
      bad_count++;
      print_verdict();
   end
   initial begin
      {nrst, psel, penable, pwrite} = 4'h0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      rd(A_FL, q); chk(q, 32'h00);
      wr(A_FL, 8'hFC);
      rd(A_FL, q); chk(q, 32'h04);
      rd(A_C1, q); chk(q, 32'h00);
      rd(A_C2, q); chk(q, 32'h00);
      wr(A_CT, 8'h55);
      rd(A_CT, q); chk(q, 32'hFC);
      rd(A_AL, q); chk(q, 32'hFC);
      wr(A_CB, 8'hC4);
      chk({31'h0, cmp1_en}, 32'h0);
      chk({31'h0, line_two}, 32'h1);
      wr(A_FL, 8'h00);
      chk({31'h0, cmp1_en}, 32'h1);
      repeat (30) @(posedge clk);
      wr(A_FL, 8'h04);
      // One wrap past 00 sets overflow and both compare flags
      rd(A_FL, q); chk(q, 32'h6C);
      rd(A_AL, q2);
      rd(A_FL, q); chk(q, 32'h6C);
      rd(A_CT, q); chk(q, q2);
      rd(A_C1, q);
      wr(A_C2, 8'h10);
      rd(A_FL, q); chk(q, 32'h04);
      wr(A_CT, 8'h00);
      rd(A_CT, q); chk(q, 32'hFC);
      wr(A_ST, 8'h1F);
      wr(A_MK, 8'h0F);
      wr(A_CA, 8'h02);
      pins.drive(1, 1'b1);
      chk({31'h0, irq}, 32'h0);
      rd(A_ST, q); chk(q, 32'h10);
      wr(A_CA, 8'h82);
      chk({31'h0, irq}, 32'h1);
      wr(A_CA, 8'h02);
      wr(A_MK, 8'h1F);
      chk({31'h0, irq}, 32'h1);
      wr(A_ST, 8'h10);
      chk({31'h0, irq}, 32'h0);
      rd(A_FL, q); chk(q, 32'h84);
      rd(A_P1, q); chk(q, 32'hFC);
      rd(A_FL, q); chk(q, 32'h04);
      for (int e = 0; e < 2; e++) begin
         wr(A_CB, 8'hC4 | {6'h00, e[0], 1'b0});
         for (int k = 0; k < 2; k++) begin
            lv = (k == 0);
            pins.drive(2, lv);
            rd(A_FL, q); chk({31'h0, q[4]}, {31'h0, lv == e[0]});
            rd(A_P2, q);
            if (lv == e[0]) chk(q, 32'hFC);
         end
      end
      rd(A_FL, q); chk(q, 32'h04);
      // Forced levels reach the pins only while the timer runs
      wr(A_CA, 8'h1D);
      chk({30'h0, cmp1, cmp2}, 32'h0);
      wr(A_FL, 8'h00);
      rd(A_CA, q); chk({30'h0, cmp1, cmp2}, 32'h3);
      wr(A_CA, 8'h18);
      rd(A_CA, q); chk({30'h0, line_one, line_two}, 32'h0);
      wr(A_FL, 8'h04);
      chk({30'h0, line_one, line_two}, 32'h3);
      // PWM period end at compare two sets capture flag one
      wr(A_CB, 8'hD6);
      wr(A_CT, 8'h00);
      wr(A_FL, 8'h00);
      repeat (60) @(posedge clk);
      wr(A_FL, 8'h04);
      rd(A_FL, q); chk({31'h0, q[7]}, 32'h1);
      xfer(1'b1, 12'h200, 8'hAA, q, er); chk({31'h0, er}, 32'h1);
      xfer(1'b0, 12'h200, 8'h00, q, er); chk(q, 32'h0);
      print_verdict();
   end
endmodule : timer8_status_data_regs_tb
